// ===== design/usd_pkg.sv
// Shared constants, types and helper functions of the UART symbol and frame decoder
// and of the transmitter end that drives its monitored lines.
// Assumes one clock domain at 125 MHz and an active low asynchronous reset.
package usd_pkg;

	// Register byte offsets of the decoder
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_DIV = 8'h04;
	localparam logic [7:0] OFS_IDLE = 8'h08;
	localparam logic [7:0] OFS_PAT = 8'h0C;
	localparam logic [7:0] OFS_POS = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_CLEAR = 8'h18;
	localparam logic [7:0] OFS_IRQEN = 8'h1C;
	localparam logic [7:0] OFS_LAST = 8'h20;

	// Field positions of configuration, pattern and last symbol registers
	localparam int CFG_POL = 0;
	localparam int CFG_PAR = 1;
	localparam int CFG_STOP = 3;
	localparam int CFG_SIZE = 5;
	localparam int CFG_TXEN = 9;
	localparam int PAT_MASK = 16;
	localparam int LAST_LANE = 9;
	localparam int LAST_IDX = 16;

	// Values after reset
	localparam logic [9:0] CFG_RST = 10'h101;
	localparam logic [15:0] DIV_RST = 16'h043D;
	localparam logic [15:0] IDLE_RST = 16'h2000;

	// Event bits of status, clear and enable registers
	localparam int EV_START = 0;
	localparam int EV_FRAME = 1;
	localparam int EV_SYMBOL = 2;
	localparam int EV_PATPOS = 3;
	localparam int EV_PATANY = 4;
	localparam int EV_PARITY = 5;
	localparam int EV_FRAMEERR = 6;
	localparam int EV_BREAK = 7;
	localparam int EV_N = 8;

	localparam logic [3:0] SIZE_MIN = 4'h5;
	localparam logic [3:0] SIZE_MAX = 4'h9;

	typedef enum logic [1:0] {
		PAR_NONE = 2'h0,
		PAR_EVEN = 2'h1,
		PAR_ODD = 2'h2
	} usd_par_t;

	typedef enum logic [1:0] {
		STOP_ONE = 2'h0,
		STOP_ONE_HALF = 2'h1,
		STOP_TWO = 2'h2
	} usd_stop_t;

	// Out of range sizes fall back to the nearest legal one
	function automatic logic [3:0] usd_size(input logic [3:0] sz);
		usd_size = (sz < SIZE_MIN) ? SIZE_MIN : (sz > SIZE_MAX) ? SIZE_MAX : sz;
	endfunction

	// Parity bit value expected for the low n data bits
	function automatic logic usd_par_bit(input logic [8:0] d, input logic [3:0] n, input logic [1:0] mode);
		logic ones;
		ones = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < n) begin
				ones = ones ^ d[i];
			end
		end
		usd_par_bit = (mode == PAR_ODD) ? ~ones : ones;
	endfunction

endpackage

// ===== design/usd_line_if.sv
// Monitored serial lines between a UART transmitter and the decoder.
// Both lines are driven by the transmitter end only; the decoder just watches.
`timescale 1ns/10ps
interface usd_line_if;
	logic rx_line;
	logic tx_line;
	modport xmit (output rx_line, output tx_line);
	modport watch (input rx_line, input tx_line);
endinterface

// ===== design/usd_decoder.sv
// Passive UART symbol and frame decoder with register port and interrupt.
// Assumes lines synchronous to REF_CLK and a register master that never overlaps strobes.
// Notes on behaviour
// - Symbol: start, data, optional parity, stops
// - Symbols grouped into frames, pause ends frame
// - Start bit is logic zero
// - Stop bits and idle are logic one
// - No clock line, preset bit rate
// - Data bit zero first, parity last
// - One polarity setting for both lines
// - Parity none, even or odd
// - Even parity makes ones count even
// - Odd parity makes ones count odd
// - Stop length one, one half, two
// - Receive line always, transmit line optional
// - Transmit line only on instances one, three
// - Raise all listed match events
// - Data size five to nine bits
// - Idle time separates frames, marks frame start
// - Break: line low beyond one symbol
`timescale 1ns/10ps
module usd_decoder
	import usd_pkg::*;
#(
	parameter int INSTANCE_NO = 1
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RESETN,
	// Monitored lines
	usd_line_if.watch LINE,
	// Register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// Interrupt and instance pairing
	output logic IRQ,
	output logic OCCUPIES_NEXT
);

	localparam logic TX_ALLOWED = (INSTANCE_NO == 1) || (INSTANCE_NO == 3);

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_START = 6'h02,
		ST_DATA = 6'h04,
		ST_PAR = 6'h08,
		ST_STOP = 6'h10,
		ST_STOP2 = 6'h20
	} usd_dst_t;

	typedef struct packed {
		usd_dst_t st;
		logic [15:0] cnt;
		logic [3:0] bitn;
		logic [8:0] shr;
		logic [15:0] idle;
		logic in_frame;
		logic [11:0] idx;
		logic [19:0] low;
		logic brk_done;
	} usd_lane_t;

	typedef struct packed {
		usd_lane_t [1:0] ln;
		logic [9:0] cfg;
		logic [15:0] div;
		logic [15:0] idle;
		logic [31:0] pat;
		logic [11:0] pos;
		logic [EV_N-1:0] status;
		logic [EV_N-1:0] en;
		logic [31:0] last;
		logic [31:0] rdata;
		logic irq;
		logic occ;
	} usd_dec_t;

	localparam usd_lane_t LANE_RST = '{st: ST_IDLE, default: '0};

	usd_dec_t q;
	usd_dec_t d;

	logic pol;
	logic [1:0] par;
	logic [1:0] stop;
	logic [3:0] dsize;
	logic [15:0] half;
	logic [15:0] bitend;
	logic [3:0] nbits;
	logic [19:0] symc;
	logic [1:0] lines;
	logic [1:0] lane_on;

	always_comb begin
		pol = q.cfg[CFG_POL];
		par = q.cfg[CFG_PAR +: 2];
		stop = q.cfg[CFG_STOP +: 2];
		dsize = usd_size(q.cfg[CFG_SIZE +: 4]);
		half = q.div >> 1;
		bitend = q.div - 16'h0001;
		nbits = 4'h1 + dsize + 4'((par != PAR_NONE)) + ((stop == STOP_TWO) ? 4'h2 : 4'h1);
		symc = 20'(q.div) * 20'(nbits);
		// Same polarity for both lines, so one physical convention per bus
		lines = pol ? {LINE.tx_line, LINE.rx_line} : ~{LINE.tx_line, LINE.rx_line};
		lane_on = {q.occ, 1'b1};
	end

	always_comb begin
		logic [1:0][EV_N-1:0] ev;
		logic b;
		logic hit;
		usd_lane_t l;
		usd_lane_t n;
		ev = '0;
		b = 1'b1;
		hit = 1'b0;
		l = LANE_RST;
		n = LANE_RST;
		d = q;
		for (int k = 0; k < 2; k++) begin
			l = q.ln[k];
			n = l;
			b = lines[k];
			n.cnt = l.cnt + 16'h0001;
			// Break watch runs beside the symbol machine
			if (!b) begin
				if (l.low != 20'hFFFFF) begin
					n.low = l.low + 20'h00001;
				end
				if (l.low == symc && !l.brk_done) begin
					ev[k][EV_BREAK] = 1'b1;
					n.brk_done = 1'b1;
				end
			end else begin
				n.low = '0;
				n.brk_done = 1'b0;
			end
			unique case (l.st)
				ST_IDLE: begin
					n.cnt = '0;
					if (b && l.idle != 16'hFFFF) begin
						n.idle = l.idle + 16'h0001;
					end
					if (!b) begin
						n.st = ST_START;
						if (!l.in_frame || l.idle >= q.idle) begin
							ev[k][EV_FRAME] = 1'b1;
							n.idx = '0;
						end
						n.in_frame = 1'b1;
					end
				end
				ST_START: begin
					if (l.cnt == half - 16'h0001) begin
						n.cnt = '0;
						n.bitn = '0;
						n.shr = '0;
						if (!b) begin
							ev[k][EV_START] = 1'b1;
							n.st = ST_DATA;
						end else begin
							n.st = ST_IDLE;
						end
					end
				end
				ST_DATA: begin
					if (l.cnt == bitend) begin
						n.cnt = '0;
						n.shr[l.bitn] = b;
						n.bitn = l.bitn + 4'h1;
						if (l.bitn == dsize - 4'h1) begin
							n.st = (par == PAR_NONE) ? ST_STOP : ST_PAR;
						end
					end
				end
				ST_PAR: begin
					if (l.cnt == bitend) begin
						n.cnt = '0;
						n.st = ST_STOP;
						if (b != usd_par_bit(l.shr, dsize, par)) begin
							ev[k][EV_PARITY] = 1'b1;
						end
					end
				end
				ST_STOP: begin
					if (l.cnt == bitend) begin
						n.cnt = '0;
						n.idle = '0;
						hit = ((l.shr ^ q.pat[8:0]) & q.pat[PAT_MASK +: 9]) == 9'h000;
						ev[k][EV_FRAMEERR] = !b;
						ev[k][EV_SYMBOL] = (l.idx == q.pos);
						ev[k][EV_PATPOS] = hit && (l.idx == q.pos);
						ev[k][EV_PATANY] = hit;
						d.last = 32'(l.shr) | (32'(k) << LAST_LANE) | (32'(l.idx) << LAST_IDX);
						if (l.idx != 12'hFFF) begin
							n.idx = l.idx + 12'h001;
						end
						// A half stop bit is not checked; idle watch resumes from the middle of the first stop bit
						n.st = (b && stop == STOP_TWO) ? ST_STOP2 : ST_IDLE;
					end
				end
				ST_STOP2: begin
					if (l.cnt == bitend) begin
						n.cnt = '0;
						n.idle = '0;
						ev[k][EV_FRAMEERR] = !b;
						n.st = ST_IDLE;
					end
				end
				default: begin
					n = LANE_RST;
				end
			endcase
			d.ln[k] = lane_on[k] ? n : LANE_RST;
			if (!lane_on[k]) begin
				ev[k] = '0;
			end
		end

		// Register writes
		if (WR) begin
			unique case (ADDR)
				OFS_CFG: begin
					d.cfg = WDATA[9:0];
					d.cfg[CFG_TXEN] = WDATA[CFG_TXEN] & TX_ALLOWED;
				end
				OFS_DIV: d.div = (WDATA[15:0] < 16'h0002) ? 16'h0002 : WDATA[15:0];
				OFS_IDLE: d.idle = WDATA[15:0];
				OFS_PAT: d.pat = WDATA & 32'h01FF_01FF;
				OFS_POS: d.pos = WDATA[11:0];
				OFS_IRQEN: d.en = WDATA[EV_N-1:0];
				default: begin
				end
			endcase
		end
		// A new event outranks a clear in the same cycle
		d.status = (q.status & ~((WR && ADDR == OFS_CLEAR) ? WDATA[EV_N-1:0] : '0)) | ev[0] | ev[1];
		d.irq = |(d.status & d.en);
		d.occ = d.cfg[CFG_TXEN];

		// Read data stands only in the cycle after the strobe
		d.rdata = '0;
		if (RD) begin
			unique case (ADDR)
				OFS_CFG: d.rdata = 32'(q.cfg);
				OFS_DIV: d.rdata = 32'(q.div);
				OFS_IDLE: d.rdata = 32'(q.idle);
				OFS_PAT: d.rdata = q.pat;
				OFS_POS: d.rdata = 32'(q.pos);
				OFS_STATUS: d.rdata = 32'(q.status);
				OFS_IRQEN: d.rdata = 32'(q.en);
				OFS_LAST: d.rdata = q.last;
				default: d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			q <= '{ln: {LANE_RST, LANE_RST}, cfg: CFG_RST, div: DIV_RST, idle: IDLE_RST, default: '0};
		end else begin
			q <= d;
		end
	end

	assign RDATA = q.rdata;
	assign IRQ = q.irq;
	assign OCCUPIES_NEXT = q.occ;

endmodule

// ===== design/usd_sender.sv
// UART transmitter end: serialises symbols onto the receive or transmit line.
// Assumes the user holds configuration steady while a symbol is in flight.
`timescale 1ns/10ps
module usd_sender
	import usd_pkg::*;
(
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RESETN,
	// Line format
	input wire logic POLARITY,
	input wire logic [1:0] PARITY,
	input wire logic [1:0] STOP_BITS,
	input wire logic [3:0] DATA_SIZE,
	input wire logic [15:0] BIT_DIV,
	// Symbol request
	input wire logic SEND_VALID,
	input wire logic [8:0] SEND_DATA,
	input wire logic SEND_LANE,
	input wire logic SEND_BREAK,
	output logic SEND_READY,
	// Lines
	usd_line_if.xmit LINE
);

	typedef enum logic [4:0] {
		TX_IDLE = 5'h01,
		TX_START = 5'h02,
		TX_DATA = 5'h04,
		TX_PAR = 5'h08,
		TX_STOP = 5'h10
	} usd_tst_t;

	typedef struct packed {
		usd_tst_t st;
		logic [15:0] cnt;
		logic [3:0] bitn;
		logic [8:0] shr;
		logic lane;
		logic [1:0] par;
		logic [1:0] stop;
		logic [3:0] size;
		logic [15:0] div;
		logic [1:0] bits;
		logic [1:0] phys;
		logic ready;
	} usd_snd_t;

	usd_snd_t q;
	usd_snd_t d;

	logic [15:0] stopc;
	logic last;

	always_comb begin
		unique case (q.stop)
			STOP_ONE_HALF: stopc = q.div + (q.div >> 1);
			STOP_TWO: stopc = q.div << 1;
			default: stopc = q.div;
		endcase
		last = (q.cnt == ((q.st == TX_STOP) ? stopc : q.div) - 16'h0001);
	end

	always_comb begin
		d = q;
		d.cnt = q.cnt + 16'h0001;
		unique case (q.st)
			TX_IDLE: begin
				d.cnt = '0;
				d.bits = 2'b11;
				if (SEND_VALID) begin
					d.st = TX_START;
					d.shr = SEND_DATA;
					d.lane = SEND_LANE;
					d.par = PARITY;
					d.stop = STOP_BITS;
					d.size = usd_size(DATA_SIZE);
					d.div = (BIT_DIV < 16'h0002) ? 16'h0002 : BIT_DIV;
					d.bits[SEND_LANE] = 1'b0;
				end else if (SEND_BREAK) begin
					d.bits[SEND_LANE] = 1'b0;
				end
			end
			TX_START: begin
				if (last) begin
					d.cnt = '0;
					d.bitn = '0;
					d.st = TX_DATA;
					d.bits[q.lane] = q.shr[0];
				end
			end
			TX_DATA: begin
				if (last) begin
					d.cnt = '0;
					d.bitn = q.bitn + 4'h1;
					if (q.bitn == q.size - 4'h1) begin
						d.st = (q.par == PAR_NONE) ? TX_STOP : TX_PAR;
						d.bits[q.lane] = (q.par == PAR_NONE) ? 1'b1 : usd_par_bit(q.shr, q.size, q.par);
					end else begin
						d.bits[q.lane] = q.shr[q.bitn + 4'h1];
					end
				end
			end
			TX_PAR: begin
				if (last) begin
					d.cnt = '0;
					d.st = TX_STOP;
					d.bits[q.lane] = 1'b1;
				end
			end
			TX_STOP: begin
				if (last) begin
					d.cnt = '0;
					d.st = TX_IDLE;
				end
			end
			default: d.st = TX_IDLE;
		endcase
		d.ready = (d.st == TX_IDLE);
		d.phys = POLARITY ? d.bits : ~d.bits;
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			q <= '{st: TX_IDLE, stop: STOP_ONE, size: 4'h8, div: DIV_RST, bits: 2'b11, phys: 2'b11,
				ready: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

	assign SEND_READY = q.ready;
	assign LINE.rx_line = q.phys[0];
	assign LINE.tx_line = q.phys[1];

endmodule

// ===== sim/usd_line_chk.sv
// Checker on the monitored lines and the sender request side.
// Assumes the bench runs the bit divider at four cycles per bit.
`timescale 1ns/10ps
module usd_line_chk
	import usd_pkg::*;
(
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RESETN,
	// Sender side
	input wire logic POLARITY,
	input wire logic [1:0] PARITY,
	input wire logic [1:0] STOP_BITS,
	input wire logic [3:0] DATA_SIZE,
	input wire logic SEND_VALID,
	input wire logic SEND_LANE,
	input wire logic SEND_BREAK,
	input wire logic SEND_READY,
	// Lines
	input wire logic rx_line,
	input wire logic tx_line
);
	logic pol_q;
	logic lane_q;
	logic [7:0] cnt_q;
	logic [7:0] len;
	wire logic lrx;
	wire logic ltx;
	// Polarity is delayed a cycle because the sender lines come from a flop
	assign lrx = rx_line ~^ pol_q;
	assign ltx = tx_line ~^ pol_q;
	always_comb begin
		len = 8'((5'd1 + 5'(DATA_SIZE) + 5'(PARITY != 2'h0)) * 4);
		len = len + ((STOP_BITS == 2'h0) ? 8'h4 : (STOP_BITS == 2'h1) ? 8'h6 : 8'h8);
	end
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			pol_q <= 1'b1;
			lane_q <= 1'b0;
			cnt_q <= 8'h0;
		end else begin
			pol_q <= POLARITY;
			cnt_q <= SEND_READY ? 8'h0 : cnt_q + 8'h1;
			if (SEND_VALID && SEND_READY) begin
				lane_q <= SEND_LANE;
			end
		end
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);
	a_idle_high: assert property (SEND_READY && !SEND_BREAK && !$past(SEND_BREAK) |-> lrx && ltx)
		else $error("idle line not at logic one");
	a_rx_start: assert property (SEND_VALID && SEND_READY && !SEND_LANE |=> !lrx && !SEND_READY)
		else $error("receive start bit missing");
	a_tx_start: assert property (SEND_VALID && SEND_READY && SEND_LANE |=> !ltx && !SEND_READY)
		else $error("transmit start bit missing");
	a_bit_hold: assert property ($changed(lrx) |=> $stable(lrx) [*3])
		else $error("bit shorter than four cycles");
	a_break_low: assert property (SEND_BREAK && SEND_READY && !SEND_LANE |=> !lrx)
		else $error("break not held low");
	a_symbol_len: assert property ($rose(SEND_READY) |-> cnt_q == len)
		else $error("symbol length wrong");
	a_lane_apart: assert property (!SEND_READY && !lane_q |-> ltx)
		else $error("transmit line moved");
	a_stop_one: assert property ($rose(SEND_READY) && !lane_q |-> $past(lrx))
		else $error("stop bit not logic one");
	a_ready_cause: assert property ($fell(SEND_READY) |-> $past(SEND_VALID))
		else $error("sender busy without request");
endmodule

// ===== sim/uart_symbol_frame_decoder_test.sv
// Bench joining sender and decoder on one line interface.
// Assumes register reads answer one cycle after the strobe.
`timescale 1ns/10ps
module uart_symbol_frame_decoder_test;
	import usd_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic pol = 1'b1;
	logic [1:0] par = 2'h0;
	logic [1:0] stp = 2'h0;
	logic [3:0] dsz = 4'h8;
	logic sv = 1'b0;
	logic [8:0] sd = 9'h0;
	logic sl = 1'b0;
	logic sb = 1'b0;
	logic sr;
	logic [7:0] addr = 8'h0;
	logic [31:0] wd = 32'h0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [31:0] rdat;
	logic irq;
	logic occ;
	int errors = 0;
	int comparisons = 0;
	usd_line_if line ();
	usd_sender usd_sender_inst (.REF_CLK(clk), .RESETN(rstn), .POLARITY(pol), .PARITY(par), .STOP_BITS(stp),
		.DATA_SIZE(dsz), .BIT_DIV(16'h4), .SEND_VALID(sv), .SEND_DATA(sd), .SEND_LANE(sl), .SEND_BREAK(sb),
		.SEND_READY(sr), .LINE(line));
	usd_decoder #(.INSTANCE_NO(1)) usd_decoder_inst (.REF_CLK(clk), .RESETN(rstn), .LINE(line), .ADDR(addr),
		.WDATA(wd), .WR(wr_s), .RD(rd_s), .RDATA(rdat), .IRQ(irq), .OCCUPIES_NEXT(occ));
	usd_line_chk usd_line_chk_inst (.REF_CLK(clk), .RESETN(rstn), .POLARITY(pol), .PARITY(par),
		.STOP_BITS(stp), .DATA_SIZE(dsz), .SEND_VALID(sv), .SEND_LANE(sl), .SEND_BREAK(sb),
		.SEND_READY(sr), .rx_line(line.rx_line), .tx_line(line.tx_line));
	always #4 clk = ~clk;
	task automatic final_report;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		// One idle edge so a following write never reassigns the strobe in this time step
		@(posedge clk);
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk(n, e, rdat & m);
		@(posedge clk);
	endtask
	task automatic send(input logic [8:0] d, input logic l);
		int k;
		sd <= d;
		sl <= l;
		sv <= 1'b1;
		@(posedge clk);
		sv <= 1'b0;
		k = 0;
		#1;
		while (sr !== 1'b1 && k < 500) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k == 500) begin
			errors++;
		end
		@(posedge clk);
	endtask
	// Sender and decoder share one format; pd lets the decoder disagree on parity
	task automatic cfg(input logic p, input logic [1:0] ps, input logic [1:0] pd, input logic [1:0] s,
		input logic [3:0] z, input logic t);
		pol <= p;
		par <= ps;
		stp <= s;
		dsz <= z;
		wr(OFS_CFG, {22'h0, t, z, s, pd, p});
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		final_report();
	end
	initial begin
		logic [3:0] z;
		logic [1:0] ps;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd("cfg", OFS_CFG, 32'(CFG_RST), '1);
		rd("div", OFS_DIV, 32'(DIV_RST), '1);
		rd("unmapped", 8'h24, 32'h0, '1);
		wr(OFS_DIV, 32'h4);
		wr(OFS_IDLE, 32'h14);
		wr(OFS_IRQEN, 32'hFF);
		wr(OFS_PAT, 32'h01FF_00A5);
		send(9'h0A5, 1'b0);
		rd("status", OFS_STATUS, 32'h1F, '1);
		rd("last", OFS_LAST, 32'hA5, '1);
		chk("irq", 32'h1, {31'h0, irq});
		wr(OFS_CLEAR, 32'hFF);
		rd("cleared", OFS_STATUS, 32'h0, '1);
		chk("irq", 32'h0, {31'h0, irq});
		$display("events done");
		for (int i = 0; i < 6; i++) begin
			z = 4'(5 + i % 5);
			ps = 2'(i % 3);
			cfg(1'b1, ps, (i < 4) ? ps : 2'h3 - ps, 2'((i + 1) % 3), z, 1'b0);
			send(9'h1B5, 1'b0);
			rd("parity", OFS_STATUS, (i >= 4) ? 32'h20 : 32'h0, 32'hE0);
			rd("data", OFS_LAST, 32'h1B5 & ((32'h1 << z) - 32'h1), 32'h1FF);
			wr(OFS_CLEAR, 32'hFF);
		end
		$display("formats done");
		cfg(1'b1, 2'h0, 2'h0, 2'h0, 4'h9, 1'b0);
		wr(OFS_CFG, 32'h101);
		send(9'h0A5, 1'b0);
		rd("framing", OFS_STATUS, 32'h40, 32'hE0);
		wr(OFS_CLEAR, 32'hFF);
		cfg(1'b1, 2'h0, 2'h0, 2'h0, 4'h8, 1'b0);
		sb <= 1'b1;
		repeat (60) @(posedge clk);
		sb <= 1'b0;
		repeat (10) @(posedge clk);
		rd("break", OFS_STATUS, 32'hC0, 32'hE0);
		$display("errors done");
		cfg(1'b0, 2'h0, 2'h0, 2'h0, 4'h8, 1'b0);
		repeat (100) @(posedge clk);
		wr(OFS_CLEAR, 32'hFF);
		send(9'h0C3, 1'b0);
		wr(OFS_CLEAR, 32'hFF);
		send(9'h03C, 1'b0);
		rd("frame", OFS_STATUS, 32'h1, 32'hFF);
		rd("index", OFS_LAST, 32'h0001_003C, 32'h0FFF_03FF);
		$display("polarity done");
		cfg(1'b1, 2'h0, 2'h0, 2'h0, 4'h8, 1'b1);
		send(9'h05A, 1'b1);
		rd("lane", OFS_LAST, 32'h25A, 32'h3FF);
		chk("occupies", 32'h1, {31'h0, occ});
		$display("lanes done");
		final_report();
	end
endmodule
